// File: rtl/tki_pkg.sv
// Constants and state types of the timer and key interrupt control block.
// Assumes a 32-bit AXI4-Lite master on CLOCK and on-chip timer outputs on the same clock.
package tki_pkg;

  localparam int unsigned AW = 12;

  // Printed offsets are register indices; byte address is four times the index.
  localparam logic [7:0] KEY_MASK_IDX = 8'hE8;
  localparam logic [7:0] TMR_MASK_IDX = 8'hEB;
  localparam logic [7:0] KEY_FLAG_IDX = 8'hED;
  localparam logic [7:0] TMR_FLAG_IDX = 8'hEF;
  localparam logic [7:0] GIE_IDX      = 8'hF0;
  localparam logic [7:0] EV_STAT_IDX  = 8'hF1;
  localparam logic [7:0] EV_MASK_IDX  = 8'hF2;

  localparam logic [AW-1:0] KEY_MASK_ADDR = {2'h0, KEY_MASK_IDX, 2'h0};
  localparam logic [AW-1:0] TMR_MASK_ADDR = {2'h0, TMR_MASK_IDX, 2'h0};
  localparam logic [AW-1:0] KEY_FLAG_ADDR = {2'h0, KEY_FLAG_IDX, 2'h0};
  localparam logic [AW-1:0] TMR_FLAG_ADDR = {2'h0, TMR_FLAG_IDX, 2'h0};
  localparam logic [AW-1:0] GIE_ADDR      = {2'h0, GIE_IDX, 2'h0};
  localparam logic [AW-1:0] EV_STAT_ADDR  = {2'h0, EV_STAT_IDX, 2'h0};
  localparam logic [AW-1:0] EV_MASK_ADDR  = {2'h0, EV_MASK_IDX, 2'h0};

  // Timer bit positions: fast (32 Hz), mid (8 Hz), slow (2 Hz); event status adds key at bit 3.
  localparam int unsigned TMR_FAST_BIT = 0;
  localparam int unsigned TMR_MID_BIT  = 1;
  localparam int unsigned TMR_SLOW_BIT = 2;
  localparam int unsigned KEY_EV_BIT   = 3;

  localparam logic [3:0] KEY_MASK_RST = 4'h0;
  localparam logic [2:0] TMR_MASK_RST = 3'h0;
  localparam logic [2:0] TMR_FLAG_RST = 3'h0;
  localparam logic       KEY_FLAG_RST = 1'h0;
  localparam logic       GIE_RST      = 1'h0;
  localparam logic [3:0] EV_RST       = 4'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
  } tki_sync_t;

  typedef struct packed {
    logic [6:0] prev;
  } tki_edge_t;

  typedef struct packed {
    logic          aw_got;
    logic [AW-1:0] aw_addr;
    logic          w_got;
    logic [3:0]    w_data;
    logic          w_lane0;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
    logic [3:0]    key_mask;
    logic [2:0]    tmr_mask;
    logic          key_flag;
    logic [2:0]    tmr_flag;
    logic          gie;
    logic [3:0]    ev_stat;
    logic [3:0]    ev_mask;
    logic          cpu_req;
    logic          irq;
  } tki_state_t;

endpackage

// File: rtl/tki_sync.sv
// Two-stage synchroniser for the four key input pins.
// Assumes the pins are asynchronous to CLOCK.
`timescale 1ns/1ps
module tki_sync (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic [3:0] din,
  output logic      [3:0] dout
);

  tki_pkg::tki_sync_t st_r;
  tki_pkg::tki_sync_t st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = din;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.s2;

endmodule

// File: rtl/tki_edge.sv
// Rising and falling edge detector over seven same-clock signals.
// Assumes every input is already in the CLOCK domain.
`timescale 1ns/1ps
module tki_edge (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic [6:0] din,
  output logic      [6:0] rise,
  output logic      [6:0] fall
);

  tki_pkg::tki_edge_t st_r;
  tki_pkg::tki_edge_t st_nxt;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.prev = din;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 7; i++) begin : g_bit
      assign rise[i] = ce & din[i] & ~st_r.prev[i];
      assign fall[i] = ce & ~din[i] & st_r.prev[i];
    end
  endgenerate

endmodule

// File: rtl/tki_top.sv
// Timer and key interrupt control bank with an AXI4-Lite register slave.
// Assumes TIMER_* come from on-chip logic on CLOCK, KEY_PINS from outside, CPU_IRQ_ACK from the CPU core.
`timescale 1ns/1ps
module tki_top (
  input  wire logic        CLOCK,
  input  wire logic        RESET_N,
  input  wire logic        CLK_EN,
  input  wire logic [11:0] S_AXI_AWADDR,
  input  wire logic [2:0]  S_AXI_AWPROT,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [11:0] S_AXI_ARADDR,
  input  wire logic [2:0]  S_AXI_ARPROT,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic [3:0]  KEY_PINS,
  input  wire logic        TIMER_FAST,
  input  wire logic        TIMER_MID,
  input  wire logic        TIMER_SLOW,
  input  wire logic        CPU_IRQ_ACK,
  output logic             CPU_IRQ_REQ,
  output logic             IRQ
);

  ////////////////////////////////////////////////////////////////////////////////
  // State and edge sources.

  tki_pkg::tki_state_t st_r;
  tki_pkg::tki_state_t st_nxt;

  logic [3:0] key_sync;
  logic [6:0] edge_in;
  logic [6:0] edge_rise;
  logic [6:0] edge_fall;

  tki_sync u_sync (
    .clk   (CLOCK),
    .rst_n (RESET_N),
    .ce    (CLK_EN),
    .din   (KEY_PINS),
    .dout  (key_sync)
  );

  assign edge_in = {key_sync, TIMER_SLOW, TIMER_MID, TIMER_FAST};

  tki_edge u_edge (
    .clk   (CLOCK),
    .rst_n (RESET_N),
    .ce    (CLK_EN),
    .din   (edge_in),
    .rise  (edge_rise),
    .fall  (edge_fall)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Source events.

  logic [2:0] tmr_set;
  logic [3:0] key_pin_set;
  logic       key_set;

  assign tmr_set = edge_fall[2:0];

  assign key_pin_set = edge_rise[6:3] & st_r.key_mask;
  assign key_set     = |key_pin_set;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus handshakes.

  logic aw_take;
  logic w_take;
  logic wr_fire;
  logic rd_take;

  assign S_AXI_AWREADY = CLK_EN & ~st_r.aw_got & ~st_r.bvalid;
  assign S_AXI_WREADY  = CLK_EN & ~st_r.w_got & ~st_r.bvalid;
  assign S_AXI_ARREADY = CLK_EN & ~st_r.rvalid;

  assign aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
  assign w_take  = S_AXI_WVALID & S_AXI_WREADY;
  assign wr_fire = st_r.aw_got & st_r.w_got & ~st_r.bvalid;
  assign rd_take = S_AXI_ARVALID & S_AXI_ARREADY;

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode helpers.

  function automatic logic is_mapped(input logic [11:0] a);
    logic hit;
    hit = 1'b0;
    case (a)
      tki_pkg::KEY_MASK_ADDR: hit = 1'b1;
      tki_pkg::TMR_MASK_ADDR: hit = 1'b1;
      tki_pkg::KEY_FLAG_ADDR: hit = 1'b1;
      tki_pkg::TMR_FLAG_ADDR: hit = 1'b1;
      tki_pkg::GIE_ADDR:      hit = 1'b1;
      tki_pkg::EV_STAT_ADDR:  hit = 1'b1;
      tki_pkg::EV_MASK_ADDR:  hit = 1'b1;
      default:                hit = 1'b0;
    endcase
    return hit;
  endfunction

  function automatic logic [31:0] read_mux(input logic [11:0] a, input tki_pkg::tki_state_t s);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      tki_pkg::KEY_MASK_ADDR: d[3:0] = s.key_mask;
      tki_pkg::TMR_MASK_ADDR: d[2:0] = s.tmr_mask;
      tki_pkg::KEY_FLAG_ADDR: d[0]   = s.key_flag;
      tki_pkg::TMR_FLAG_ADDR: d[2:0] = s.tmr_flag;
      tki_pkg::GIE_ADDR:      d[0]   = s.gie;
      tki_pkg::EV_STAT_ADDR:  d[3:0] = s.ev_stat;
      tki_pkg::EV_MASK_ADDR:  d[3:0] = s.ev_mask;
      default:                d      = 32'h0000_0000;
    endcase
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  logic [3:0] ev_set;

  assign ev_set = {key_set, tmr_set};

  always_comb begin
    st_nxt = st_r;

    // Write address and data are taken independently, in either order.
    if (aw_take) begin
      st_nxt.aw_got  = 1'b1;
      st_nxt.aw_addr = S_AXI_AWADDR;
    end
    if (w_take) begin
      st_nxt.w_got   = 1'b1;
      st_nxt.w_data  = S_AXI_WDATA[3:0];
      st_nxt.w_lane0 = S_AXI_WSTRB[0];
    end

    if (S_AXI_BVALID && S_AXI_BREADY) begin
      st_nxt.bvalid = 1'b0;
    end
    if (S_AXI_RVALID && S_AXI_RREADY) begin
      st_nxt.rvalid = 1'b0;
    end

    // Register writes once both halves are held.
    if (wr_fire) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = is_mapped(st_r.aw_addr) ? tki_pkg::RESP_OKAY : tki_pkg::RESP_SLVERR;
      if (st_r.w_lane0) begin
        case (st_r.aw_addr)
          tki_pkg::KEY_MASK_ADDR: st_nxt.key_mask = st_r.w_data;
          tki_pkg::TMR_MASK_ADDR: st_nxt.tmr_mask = st_r.w_data[2:0];
          tki_pkg::GIE_ADDR:      st_nxt.gie      = st_r.w_data[0];
          tki_pkg::EV_STAT_ADDR:  st_nxt.ev_stat  = st_r.ev_stat & ~st_r.w_data;
          tki_pkg::EV_MASK_ADDR:  st_nxt.ev_mask  = st_r.w_data;
          default:                st_nxt.ev_mask  = st_nxt.ev_mask;
        endcase
      end
    end

    // Register reads; data is registered and shown with RVALID.
    if (rd_take) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = read_mux(S_AXI_ARADDR, st_r);
      st_nxt.rresp  = is_mapped(S_AXI_ARADDR) ? tki_pkg::RESP_OKAY : tki_pkg::RESP_SLVERR;
      if (S_AXI_ARADDR == tki_pkg::KEY_FLAG_ADDR) begin
        st_nxt.key_flag = 1'b0;
      end
      if (S_AXI_ARADDR == tki_pkg::TMR_FLAG_ADDR) begin
        st_nxt.tmr_flag = 3'h0;
      end
    end

    // key and timer flags
    // New edges win over a clearing read in the same cycle.
    st_nxt.key_flag = st_nxt.key_flag | key_set;
    st_nxt.tmr_flag = st_nxt.tmr_flag | tmr_set;

    // Sticky event status; a new event wins over a write-one clear.
    st_nxt.ev_stat = st_nxt.ev_stat | ev_set;

    if (CPU_IRQ_ACK) begin
      st_nxt.gie = 1'b0;
    end

    st_nxt.cpu_req = st_r.gie & ~CPU_IRQ_ACK
                   & ((st_r.key_flag & (|st_r.key_mask)) | (|(st_r.tmr_flag & st_r.tmr_mask)));

    st_nxt.irq = |(st_r.ev_stat & st_r.ev_mask);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_r          <= '0;
      st_r.key_mask <= tki_pkg::KEY_MASK_RST;
      st_r.tmr_mask <= tki_pkg::TMR_MASK_RST;
      st_r.key_flag <= tki_pkg::KEY_FLAG_RST;
      st_r.tmr_flag <= tki_pkg::TMR_FLAG_RST;
      st_r.gie      <= tki_pkg::GIE_RST;
      st_r.ev_stat  <= tki_pkg::EV_RST;
      st_r.ev_mask  <= tki_pkg::EV_RST;
    end else if (CLK_EN) begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign S_AXI_BVALID = st_r.bvalid;
  assign S_AXI_BRESP  = st_r.bresp;
  assign S_AXI_RVALID = st_r.rvalid;
  assign S_AXI_RDATA  = st_r.rdata;
  assign S_AXI_RRESP  = st_r.rresp;
  assign CPU_IRQ_REQ  = st_r.cpu_req;
  assign IRQ          = st_r.irq;

endmodule

// File: testbench/tki_chk.sv
// Checker of the interrupt control bank ports.
// Assumes it is bound to tki_top and sees only its ports.
`timescale 1ns/1ps
module tki_chk (
  input wire logic        CLOCK,
  input wire logic        RESET_N,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic        CPU_IRQ_ACK,
  input wire logic        CPU_IRQ_REQ
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  a_ack_clears_req: assert property (CPU_IRQ_ACK |=> !CPU_IRQ_REQ)
    else $error("request stayed after acknowledge");
  a_req_not_acked: assert property ($rose(CPU_IRQ_REQ) |-> !$past(CPU_IRQ_ACK))
    else $error("request rose right after acknowledge");
  a_rd_unused_zero: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:4] == 28'h0)
    else $error("unused read bits not zero");
  a_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read answer dropped or changed");
  a_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write answer dropped or changed");
  a_ar_block: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read address taken during answer");
  a_aw_block: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken during answer");
  a_rd_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
endmodule
bind tki_top tki_chk u_chk (.*);

// File: testbench/tki_cpu_model.sv
// CPU core side: acknowledges a request after a chosen number of cycles.
// Assumes the request is a level on CLOCK.
`timescale 1ns/1ps
module tki_cpu_model (
  input wire logic       CLOCK,
  input wire logic       RESET_N,
  input wire logic [3:0] dly,
  input wire logic       CPU_IRQ_REQ,
  output logic           CPU_IRQ_ACK
);
  logic [3:0] cnt_r;
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      cnt_r       <= 4'h0;
      CPU_IRQ_ACK <= 1'b0;
    end else begin
      CPU_IRQ_ACK <= CPU_IRQ_REQ && !CPU_IRQ_ACK && cnt_r >= dly;
      cnt_r       <= (CPU_IRQ_REQ && !CPU_IRQ_ACK && cnt_r < dly) ? cnt_r + 4'h1 : 4'h0;
    end
  end
endmodule

// File: testbench/tb.sv
// Register and event tests of the interrupt control bank.
// Assumes a 50 MHz clock and the CPU model as acknowledging partner.
`timescale 1ns/1ps
module tb;
  logic CLOCK = 0, RESET_N = 0, AWV = 0, WV = 0, BR = 0, ARV = 0, RR = 0;
  logic [11:0] AWA = 0, ARA = 0;
  logic [31:0] WD = 0, RD;
  logic [1:0] BRS, RRS;
  logic AWR, WR, BV, ARR, RV, ACK, REQ, IRQ;
  logic [3:0] KEYS = 0, dly = 0;
  logic [2:0] TMR = 0;
  logic CE = 1;
  int errors = 0, total_checks = 0, cyc = 0, i;
  logic [11:0] adr [5] = '{tki_pkg::KEY_MASK_ADDR, tki_pkg::TMR_MASK_ADDR, tki_pkg::KEY_FLAG_ADDR,
                          tki_pkg::TMR_FLAG_ADDR, tki_pkg::GIE_ADDR};
  tki_top dut (.CLOCK(CLOCK), .RESET_N(RESET_N), .CLK_EN(CE), .S_AXI_AWADDR(AWA), .S_AXI_AWPROT(3'h0),
    .S_AXI_AWVALID(AWV), .S_AXI_AWREADY(AWR), .S_AXI_WDATA(WD), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(WV),
    .S_AXI_WREADY(WR), .S_AXI_BRESP(BRS), .S_AXI_BVALID(BV), .S_AXI_BREADY(BR), .S_AXI_ARADDR(ARA),
    .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(ARV), .S_AXI_ARREADY(ARR), .S_AXI_RDATA(RD), .S_AXI_RRESP(RRS),
    .S_AXI_RVALID(RV), .S_AXI_RREADY(RR), .KEY_PINS(KEYS), .TIMER_FAST(TMR[0]), .TIMER_MID(TMR[1]),
    .TIMER_SLOW(TMR[2]), .CPU_IRQ_ACK(ACK), .CPU_IRQ_REQ(REQ), .IRQ(IRQ));
  tki_cpu_model cpu (.CLOCK(CLOCK), .RESET_N(RESET_N), .dly(dly), .CPU_IRQ_REQ(REQ), .CPU_IRQ_ACK(ACK));
  initial begin
    forever #10 CLOCK = ~CLOCK;
  end
  task end_of_test;
    if (errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_of_test;
    end
  end
  task ck(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    @(posedge CLOCK);
    {aw, w} = 2'b11;
    AWA <= a; WD <= d; AWV <= 1; WV <= 1; BR <= 1;
    do begin
      @(posedge CLOCK);
      if (aw && AWR) begin aw = 0; AWV <= 0; end
      if (w && WR) begin w = 0; WV <= 0; end
    end while (!BV);
    BR <= 0;
    ck("bresp", {30'h0, er}, {30'h0, BRS});
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge CLOCK);
    ARA <= a; ARV <= 1; RR <= 1;
    do begin
      @(posedge CLOCK);
      if (ARR) ARV <= 0;
    end while (!RV);
    RR <= 0;
    ck("rdata", e, RD);
    ck("rresp", {30'h0, er}, {30'h0, RRS});
  endtask
  task fall(input int n);
    @(posedge CLOCK) TMR[n] <= 1;
    repeat (2) @(posedge CLOCK);
    TMR[n] <= 0;
    repeat (3) @(posedge CLOCK);
  endtask
  task key(input int n);
    @(posedge CLOCK) KEYS[n] <= 1;
    repeat (6) @(posedge CLOCK);
    KEYS[n] <= 0;
    repeat (6) @(posedge CLOCK);
  endtask
  initial begin
    repeat (5) @(posedge CLOCK);
    RESET_N <= 1;
    for (i = 0; i < 5; i++) rd(adr[i], 0, 0);
    wr(adr[0], 32'hFFFFFFFF, 0);
    rd(adr[0], 32'hF, 0);
    wr(adr[1], 32'hFFFFFFFF, 0);
    rd(adr[1], 32'h7, 0);
    wr(adr[3], 32'h7, 0);
    rd(adr[3], 0, 0);
    rd(12'h004, 0, tki_pkg::RESP_SLVERR);
    for (i = 0; i < 3; i++) begin
      fall(i);
      rd(adr[3], 32'h1 << i, 0);
      rd(adr[3], 0, 0);
    end
    wr(adr[0], 32'h4, 0);
    key(1);
    rd(adr[2], 0, 0);
    key(2);
    rd(adr[2], 1, 0);
    rd(adr[2], 0, 0);
    wr(adr[1], 0, 0);
    wr(adr[4], 1, 0);
    fall(1);
    ck("req", 0, REQ);
    rd(adr[3], 32'h2, 0);
    wr(adr[1], 32'h2, 0);
    fall(1);
    ck("req", 1, REQ);
    while (REQ) @(posedge CLOCK);
    rd(adr[4], 0, 0);
    rd(adr[3], 32'h2, 0);
    dly <= 4'h5;
    wr(adr[4], 1, 0);
    key(2);
    while (REQ) @(posedge CLOCK);
    rd(adr[4], 0, 0);
    wr(tki_pkg::EV_MASK_ADDR, 1, 0);
    wr(tki_pkg::EV_STAT_ADDR, 32'hF, 0);
    repeat (2) @(posedge CLOCK);
    ck("irq", 0, IRQ);
    fall(0);
    ck("irq", 1, IRQ);
    wr(tki_pkg::EV_STAT_ADDR, 32'hF, 0);
    repeat (2) @(posedge CLOCK);
    ck("irq", 0, IRQ);
    CE <= 0;
    @(posedge CLOCK);
    ck("awready", 0, AWR);
    ck("arready", 0, ARR);
    CE <= 1;
    @(posedge CLOCK);
    end_of_test;
  end
endmodule
